// [rtl/dcp_dev.sv]
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
// control port slave; samples link pins with its own clock
module dcp_dev
(
   input  wire logic       CLK,
   input  wire logic       RST_N,
   dcp_if.dev              LINK,
   output logic [63:0]     REGS,
   output logic            SPI_MODE,
   output logic            WR_STROBE
);
   typedef enum {DCP_IDLE, DCP_ADDR, DCP_PTR, DCP_DATA, DCP_ACK,
                 DCP_RD, DCP_RACK, DCP_SKIP} dcp_state_t;

   logic [2:0] scl_s_q, sda_s_q, sel_s_q;   // two-stage syncs + history
   logic       scl_r, scl_f, sda_r, sda_f, sel_f, start, stop;
   logic       spi_q, sda_oe_q, wr_q, ack_rd_q, after_ptr_q, rd_q;
   logic [7:0] sh_q, ptr_q;
   logic [3:0] cnt_q;
   logic [7:0] regs_q [dcp_pkg::NUM_REGS];
   dcp_state_t st_q;

   // synchronisers: stage 0 read only by stage 1; they run through
   // reset so the history holds the pin level on release, since a
   // fixed reset value would fake a select fall with the strap low
   always_ff @(posedge CLK)
   begin
      scl_s_q <= {scl_s_q[1:0], LINK.scl};
      sda_s_q <= {sda_s_q[1:0], LINK.sda};
      sel_s_q <= {sel_s_q[1:0], LINK.sel_pin};
   end

   assign scl_r = scl_s_q[1] & ~scl_s_q[2];
   assign scl_f = ~scl_s_q[1] & scl_s_q[2];
   assign sda_r = sda_s_q[1] & ~sda_s_q[2];
   assign sda_f = ~sda_s_q[1] & sda_s_q[2];
   assign sel_f = ~sel_s_q[1] & sel_s_q[2];
   assign start = ~spi_q & sda_f & scl_s_q[1];
   assign stop  = ~spi_q & sda_r & scl_s_q[1];

   // mode: i2c after reset, 4-wire on first select fall, sticky
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         spi_q <= 1'b0;
      else if (sel_f)
         spi_q <= 1'b1;
   end

   // frame engine shared by both modes; no audio clock involved
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         st_q        <= DCP_IDLE;
         cnt_q       <= 4'h0;
         sh_q        <= 8'h00;
         ptr_q       <= dcp_pkg::PTR_RESET;
         sda_oe_q    <= 1'b0;
         wr_q        <= 1'b0;
         ack_rd_q    <= 1'b0;
         after_ptr_q <= 1'b0;
         rd_q        <= 1'b0;
         for (int i = 0; i < dcp_pkg::NUM_REGS; i++)
            regs_q[i] <= dcp_pkg::REG_RESET;
      end
      else
      begin
         wr_q <= 1'b0;
         if (sel_f)
         begin
            // select fall opens a 4-wire frame, the very first one too
            st_q     <= DCP_ADDR;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
         end
         else if (spi_q)
         begin
            sda_oe_q <= 1'b0;
            if (sel_s_q[1])
            begin
               st_q  <= DCP_ADDR;                           // frame ends
               cnt_q <= 4'h0;
            end
            else if (scl_r && st_q != DCP_SKIP)
            begin
               sh_q  <= {sh_q[6:0], sda_s_q[1]};
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'h7)
               begin
                  cnt_q <= 4'h0;
                  unique case (st_q)
                     DCP_ADDR:
                        st_q <= ({sh_q[6:0], sda_s_q[1]} ==
                                 {dcp_pkg::SPI_CHIP_ADDR, 1'b0})
                                ? DCP_PTR : DCP_SKIP;
                     DCP_PTR:
                     begin
                        ptr_q <= {sh_q[6:0], sda_s_q[1]};
                        st_q  <= DCP_DATA;
                     end
                     default:
                     begin
                        regs_q[ptr_q[dcp_pkg::PTR_IDX_MSB:0]] <=
                           {sh_q[6:0], sda_s_q[1]};
                        wr_q <= 1'b1;
                        if (ptr_q[dcp_pkg::PTR_POINTER_AUTOINCREMENT_BIT])
                           ptr_q[2:0] <= ptr_q[2:0] + 3'h1;
                     end
                  endcase
               end
            end
         end
         else if (start)
         begin
            st_q     <= DCP_ADDR;
            cnt_q    <= 4'h0;
            sda_oe_q <= 1'b0;
         end
         else if (stop)
         begin
            st_q     <= DCP_IDLE;
            sda_oe_q <= 1'b0;
         end
         else if (scl_r && (st_q == DCP_ADDR || st_q == DCP_PTR ||
                            st_q == DCP_DATA))
         begin
            sh_q  <= {sh_q[6:0], sda_s_q[1]};
            cnt_q <= cnt_q + 4'h1;
         end
         else if (scl_r && st_q == DCP_RACK)
         begin
            rd_q <= ~sda_s_q[1];                             // master ack
         end
         else if (scl_f)
         begin
            unique case (st_q)
               DCP_ADDR, DCP_PTR, DCP_DATA:
                  if (cnt_q == 4'h8)
                  begin
                     cnt_q <= 4'h0;
                     if (st_q == DCP_ADDR)
                     begin
                        if (sh_q[7:2] == dcp_pkg::I2C_ADDR_UPPER &&
                            sh_q[1] == sel_s_q[1])
                        begin
                           sda_oe_q <= 1'b1;
                           ack_rd_q <= sh_q[0];
                           after_ptr_q <= 1'b0;
                           st_q <= DCP_ACK;
                        end
                        else
                           st_q <= DCP_IDLE;
                     end
                     else
                     begin
                        sda_oe_q <= 1'b1;
                        if (st_q == DCP_PTR)
                           ptr_q <= sh_q;
                        else
                        begin
                           regs_q[ptr_q[dcp_pkg::PTR_IDX_MSB:0]]
                              <= sh_q;
                           wr_q <= 1'b1;
                           if (ptr_q[dcp_pkg::PTR_POINTER_AUTOINCREMENT_BIT])
                              ptr_q[2:0] <= ptr_q[2:0] + 3'h1;
                        end
                        after_ptr_q <= 1'b1;
                        st_q <= DCP_ACK;
                     end
                  end
               DCP_ACK:
               begin
                  if (ack_rd_q)
                  begin
                     sh_q <= regs_q[ptr_q[dcp_pkg::PTR_IDX_MSB:0]];
                     sda_oe_q <= ~regs_q[ptr_q[2:0]][7];
                     cnt_q <= 4'h1;
                     st_q <= DCP_RD;
                     if (ptr_q[dcp_pkg::PTR_POINTER_AUTOINCREMENT_BIT])
                        ptr_q[2:0] <= ptr_q[2:0] + 3'h1;
                  end
                  else
                  begin
                     sda_oe_q <= 1'b0;
                     st_q <= after_ptr_q ? DCP_DATA : DCP_PTR;
                  end
               end
               DCP_RD:
                  if (cnt_q == 4'h8)
                  begin
                     sda_oe_q <= 1'b0;                      // release for ack
                     st_q <= DCP_RACK;
                  end
                  else
                  begin
                     sda_oe_q <= ~sh_q[7 - cnt_q[2:0]];
                     cnt_q <= cnt_q + 4'h1;
                  end
               DCP_RACK:
                  if (rd_q)
                     st_q <= DCP_ACK;                       // next byte
                  else
                     st_q <= DCP_IDLE;                      // nack ends
               default: ;
            endcase
         end
      end
   end

   // register image and status straight from flops
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         REGS      <= '0;
         SPI_MODE  <= 1'b0;
         WR_STROBE <= 1'b0;
         LINK.sda_dev_oe <= 1'b0;
      end
      else
      begin
         for (int i = 0; i < dcp_pkg::NUM_REGS; i++)
            REGS[i*8 +: 8] <= regs_q[i];
         SPI_MODE  <= spi_q;
         WR_STROBE <= wr_q;
         LINK.sda_dev_oe <= sda_oe_q & ~spi_q;
      end
   end
endmodule : dcp_dev
`default_nettype wire

// [rtl/dcp_pkg.sv]
// Summary of operation
// - transfers accepted independent of audio clocks
// - two serial modes, device always slave
// - starts in I2C, falling select enters 4-wire
// - 4-wire mode sticks until reset
// - 4-wire mode write-only, never drives lines
// - 4-wire bits sampled on rising clock edge
// - 4-wire frame opens with chip address
// - eighth 4-wire bit low means write
// - pointer byte then data byte stored
// - increment flag clear keeps pointer
// - increment flag set advances pointer per byte
// - I2C address upper six bits 001000
// - I2C address lsb matches strap pin
// - I2C eighth bit: 1 read, 0 write
// - I2C write: pointer byte then data bytes
// - I2C read returns pointed register directly
// - pointer bit 7 is increment, reset 0
// - pointer bits 2..0 index, reset 000
// - host keeps lines static when idle
// - host writes 11h to register 5 first
// - reset returns registers to defaults
package dcp_pkg;
   localparam logic [6:0] SPI_CHIP_ADDR   = 7'h10;
   localparam logic [5:0] I2C_ADDR_UPPER  = 6'h08;
   localparam int         PTR_POINTER_AUTOINCREMENT_BIT    = 7;
   localparam int         PTR_IDX_MSB     = 2;
   localparam logic [7:0] PTR_RESET       = 8'h00;
   localparam logic [7:0] REG_RESET       = 8'h00;
   localparam int         NUM_REGS        = 8;
   localparam logic [2:0] INIT_REG_IDX    = 3'h5;
   localparam logic [7:0] INIT_REG_VAL    = 8'h11;
   // apb register map of the host controller
   localparam logic [7:0] HOST_CMD_OFS    = 8'h00;
   localparam logic [7:0] HOST_STAT_OFS   = 8'h04;
   localparam logic [7:0] HOST_RDATA_OFS  = 8'h08;
   // one bit phase, a quarter period of the generated link clock, in system clocks
   localparam int         LINK_HALF_DIV   = 4;
endpackage : dcp_pkg

// [rtl/dcp_if.sv]
`timescale 1ns/10ps
`default_nettype none
// control port pins; open-drain sda resolved from the enables
interface dcp_if;
   logic scl;           // control_bit_clock / i2c clock
   logic sel_n;         // shared_address_select_pin, host side
   logic sel_oe;        // host drives select (else strap level)
   logic strap;         // slave_address_lsb_pin strap level
   logic sda_host_oe;   // host pulls sda low
   logic sda_dev_oe;    // device pulls sda low
   logic sda;           // control_serial_input / wired-and level
   logic sel_pin;
   assign sda     = ~(sda_host_oe | sda_dev_oe);
   assign sel_pin = sel_oe ? sel_n : strap;
   modport dev  (input scl, sda, sel_pin, output sda_dev_oe);
   modport host (output scl, sel_n, sel_oe, sda_host_oe, input sda);
endinterface : dcp_if
`default_nettype wire

// [rtl/dcp_host.sv]
`timescale 1ns/10ps
`default_nettype none
// host end: apb slave taking commands, runs one byte-level frame
module dcp_host
(
   input  wire logic        CLK,
   input  wire logic        RST_N,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   dcp_if.host              LINK
);
   // command: [31] go, [30] 4-wire, [29] read, [28] strap lsb,
   // [23:16] pointer, [15:8] data, [1:0] data byte count (0..3)
   logic [31:0] cmd_q;
   logic        busy_q, spi_q, ack_err_q;
   logic [39:0] bits_q;        // address, pointer, data bytes
   logic [5:0]  nbit_q, idx_q;
   logic [2:0]  div_q;
   logic [3:0]  ph_q;
   logic [7:0]  rdat_q;
   logic [1:0]  sda_s_q;
   logic        acc;

   assign acc = PSEL & PENABLE;

   // apb answers in the access cycle, zero wait
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         PRDATA  <= 32'h0000_0000;
         PREADY  <= 1'b0;
         PSLVERR <= 1'b0;
      end
      else
      begin
         PREADY  <= PSEL & ~PENABLE;
         PSLVERR <= PSEL & ~PENABLE & (PADDR > dcp_pkg::HOST_RDATA_OFS);
         unique case (PADDR)
            dcp_pkg::HOST_CMD_OFS:   PRDATA <= cmd_q;
            dcp_pkg::HOST_STAT_OFS:  PRDATA <= {29'h0, spi_q, ack_err_q,
                                                busy_q};
            dcp_pkg::HOST_RDATA_OFS: PRDATA <= {24'h0, rdat_q};
            default:                 PRDATA <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge CLK)
   begin
      if (!RST_N)
         sda_s_q <= 2'h3;
      else
         sda_s_q <= {sda_s_q[0], LINK.sda};
   end

   // bit engine: four phases per bit from divided clock
   always_ff @(posedge CLK)
   begin
      if (!RST_N)
      begin
         cmd_q <= 32'h0000_0000;
         busy_q <= 1'b0;
         spi_q <= 1'b0;
         ack_err_q <= 1'b0;
         bits_q <= '0;
         nbit_q <= '0;
         idx_q <= '0;
         div_q <= '0;
         ph_q <= '0;
         rdat_q <= 8'h00;
         LINK.scl <= 1'b1;         // static when idle
         LINK.sel_n <= 1'b1;
         LINK.sel_oe <= 1'b0;
         LINK.sda_host_oe <= 1'b0;
      end
      else if (!busy_q)
      begin
         if (acc && PREADY == 1'b1 && PWRITE &&
             PADDR == dcp_pkg::HOST_CMD_OFS)
         begin
            cmd_q <= PWDATA;
            if (PWDATA[31])
            begin
               busy_q <= 1'b1;
               ack_err_q <= 1'b0;
               spi_q <= spi_q | PWDATA[30];
               bits_q <= PWDATA[30] ?
                  {dcp_pkg::SPI_CHIP_ADDR, 1'b0, PWDATA[23:8], 16'h0000} :
                  {dcp_pkg::I2C_ADDR_UPPER, PWDATA[28], PWDATA[29],
                   PWDATA[23:8], 16'h0000};
               nbit_q <= PWDATA[29] ? 6'd16 :
                         6'(6'd16 + {PWDATA[1:0], 3'h0});
               idx_q <= '0;
               ph_q <= '0;
               div_q <= '0;
               LINK.sel_oe <= PWDATA[30];
               LINK.sel_n <= ~PWDATA[30];
               LINK.sda_host_oe <= ~PWDATA[30];             // i2c start
            end
         end
      end
      else if (div_q != 3'(dcp_pkg::LINK_HALF_DIV - 1))
         div_q <= div_q + 3'h1;
      else
      begin
         div_q <= '0;
         ph_q <= ph_q + 4'h1;
         unique case (ph_q[1:0])
            2'h0: LINK.scl <= 1'b0;
            // ack slot before stop, so the last byte is acked too
            2'h1:                                          // set data low
               if (!spi_q && idx_q[2:0] == 3'h0 && idx_q != 0 &&
                   ph_q[3:2] == 2'h1)
                  LINK.sda_host_oe <= 1'b0;                // ack slot
               else if (idx_q == nbit_q)
                  LINK.sda_host_oe <= ~spi_q;              // stop prep
               else if (cmd_q[29] && idx_q >= 6'd8)
                  LINK.sda_host_oe <= 1'b0;                // slave drives
               else
                  LINK.sda_host_oe <= ~bits_q[39 - idx_q]; // both modes
            2'h2: LINK.scl <= 1'b1;
            default:
            begin
               if (!spi_q && idx_q[2:0] == 3'h0 && idx_q != 0 &&
                   ph_q[3:2] == 2'h1)
               begin
                  // our own nack after the read byte is no error
                  if (!cmd_q[29] || idx_q != nbit_q)
                     ack_err_q <= ack_err_q | sda_s_q[1];
                  ph_q <= '0;
               end
               else if (idx_q == nbit_q)
               begin
                  busy_q <= 1'b0;
                  LINK.sel_n <= 1'b1;
                  LINK.sda_host_oe <= 1'b0;                // stop
                  cmd_q[31] <= 1'b0;
               end
               else
               begin
                  if (idx_q >= 6'd8)
                     rdat_q <= {rdat_q[6:0], sda_s_q[1]};
                  idx_q <= idx_q + 6'h1;
                  ph_q <= (!spi_q && idx_q[2:0] == 3'h7) ? 4'h4 : 4'h0;
               end
            end
         endcase
      end
   end
endmodule : dcp_host
`default_nettype wire

// [tb/dcp_link_sva.sv]
`timescale 1ns/10ps
`default_nettype none
// watches the shared control wires and the slave's outputs
module dcp_link_sva
(
   input wire logic        CLK,
   input wire logic        RST_N,
   input wire logic        scl,
   input wire logic        sel_pin,
   input wire logic        sda_dev_oe,
   input wire logic [63:0] REGS,
   input wire logic        SPI_MODE,
   input wire logic        WR_STROBE
);
   // sync reset, so defaults show one edge after a low sample
   a_reset_defaults: assert property (@(posedge CLK)
      !RST_N |=> (REGS == 64'h0 && !SPI_MODE))
      else $error("registers not cleared by reset");
   // select fall reaches the mode flag through the pin synchroniser
   a_spi_entry: assert property (@(posedge CLK) disable iff (!RST_N)
      $fell(sel_pin) && !SPI_MODE |-> ##[1:6] SPI_MODE)
      else $error("select fall did not enter 4-wire mode");
   a_spi_sticky: assert property (@(posedge CLK) disable iff (!RST_N)
      SPI_MODE |=> SPI_MODE)
      else $error("4-wire mode left without reset");
   a_spi_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
      SPI_MODE |-> !sda_dev_oe)
      else $error("slave drives data line in 4-wire mode");
   a_strobe_pulse: assert property (@(posedge CLK) disable iff (!RST_N)
      WR_STROBE |=> !WR_STROBE)
      else $error("store strobe longer than one cycle");
   a_regs_cause: assert property (@(posedge CLK) disable iff (!RST_N)
      $changed(REGS) |-> (WR_STROBE || $past(WR_STROBE)))
      else $error("register changed without a store");
   // the slave may only move sda while the clock is low
   a_ack_low_scl: assert property (@(posedge CLK) disable iff (!RST_N)
      $changed(sda_dev_oe) |-> !scl)
      else $error("slave moved sda while clock high");
   a_ack_hold: assert property (@(posedge CLK) disable iff (!RST_N)
      $rose(sda_dev_oe) |-> sda_dev_oe [*5])
      else $error("slave pull-down too short");
   // ack plus eight zero bits keeps sda low for nine bit times
   a_ack_bound: assert property (@(posedge CLK) disable iff (!RST_N)
      $rose(sda_dev_oe) |-> ##[1:160] !sda_dev_oe)
      else $error("slave holds sda low too long");
endmodule // dcp_link_sva
`default_nettype wire

// [tb/tb.sv]
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic        clk     = 1'b0;
   logic        rst_n   = 1'b0;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [7:0]  paddr   = 8'h00;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [63:0] regs;
   logic        spi_mode;
   logic        wr_strobe;
   logic [31:0] st;
   logic [31:0] rd;
   logic        er;
   int          failures = 0;
   int          checks   = 0;

   dcp_if link ();
   // strap tied high, so the shared pin idles high in i2c mode
   assign link.strap = 1'b1;
   always #50 clk = ~clk;

   dcp_dev i_dcp_dev (.CLK(clk), .RST_N(rst_n), .LINK(link.dev),
      .REGS(regs), .SPI_MODE(spi_mode), .WR_STROBE(wr_strobe));
   dcp_host i_dcp_host (.CLK(clk), .RST_N(rst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
      .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .LINK(link.host));
   dcp_link_sva i_dcp_link_sva (.CLK(clk), .RST_N(rst_n),
      .scl(link.scl), .sel_pin(link.sel_pin),
      .sda_dev_oe(link.sda_dev_oe), .REGS(regs),
      .SPI_MODE(spi_mode), .WR_STROBE(wr_strobe));

   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic close_out();
      $display("checks=%0d failures=%0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rdv,
                      output logic err);
      int n;
      n = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= adr;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         failures++;
         close_out();
      end
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   // command word: go, 4-wire, read, address lsb, pointer, data, 1 byte
   function automatic logic [31:0] cmd(input logic spi, input logic rdn,
      input logic lsb, input logic [7:0] ptr, input logic [7:0] dat);
      cmd = {1'b1, spi, rdn, lsb, 4'h0, ptr, dat, 8'h01};
   endfunction

   // issue one frame, poll busy with a bound, fetch read data
   task automatic run(input logic [31:0] c);
      int n;
      n = 0;
      apb(1'b1, dcp_pkg::HOST_CMD_OFS, c, rd, er);
      st = 32'h0000_0001;
      while (st[0] !== 1'b0 && n < 400)
      begin
         apb(1'b0, dcp_pkg::HOST_STAT_OFS, 32'h0, st, er);
         n++;
      end
      if (n >= 400)
      begin
         failures++;
         close_out();
      end
      apb(1'b0, dcp_pkg::HOST_RDATA_OFS, 32'h0, rd, er);
      cmp(link.scl, 1'b1);
   endtask

   task automatic t_reset();
      cmp(regs, 64'h0);
      cmp(spi_mode, 1'b0);
      apb(1'b0, dcp_pkg::HOST_STAT_OFS, 32'h0, st, er);
      cmp(st[2:0], 3'h0);
      $display("test reset done");
   endtask

   task automatic t_i2c_write();
      run(cmd(1'b0, 1'b0, 1'b1, {5'h00, dcp_pkg::INIT_REG_IDX},
              dcp_pkg::INIT_REG_VAL));
      cmp(st[1], 1'b0);
      cmp(regs[8*dcp_pkg::INIT_REG_IDX +: 8], dcp_pkg::INIT_REG_VAL);
      // wrong address lsb must be ignored and not acknowledged
      run(cmd(1'b0, 1'b0, 1'b0, 8'h01, 8'hFF));
      cmp(st[1], 1'b1);
      cmp(regs[15:8], 8'h00);
      $display("test i2c write done");
   endtask

   task automatic t_i2c_read();
      run(cmd(1'b0, 1'b1, 1'b1, 8'h00, 8'h00));
      cmp(rd[7:0], dcp_pkg::INIT_REG_VAL);
      $display("test i2c read done");
   endtask

   // pointer_autoincrement set: pointer moves on, so the read hits the next register
   task automatic t_pointer_autoincrement();
      run(cmd(1'b0, 1'b0, 1'b1, 8'h03, 8'h3C));
      run(cmd(1'b0, 1'b0, 1'b1, 8'h82, 8'hA5));
      cmp(regs[23:16], 8'hA5);
      run(cmd(1'b0, 1'b1, 1'b1, 8'h00, 8'h00));
      cmp(rd[7:0], 8'h3C);
      $display("test increment done");
   endtask

   task automatic t_apb_err();
      apb(1'b0, 8'h0C, 32'h0, rd, er);
      cmp(er, 1'b1);
      $display("test unmapped done");
   endtask

   // next to last test: 4-wire mode cannot be left without reset
   task automatic t_spi();
      run(cmd(1'b1, 1'b0, 1'b0, 8'h06, 8'h5A));
      cmp(spi_mode, 1'b1);
      cmp(regs[55:48], 8'h5A);
      cmp(st[2], 1'b1);
      run(cmd(1'b1, 1'b0, 1'b0, 8'h00, 8'h77));
      cmp(regs[7:0], 8'h77);
      cmp(spi_mode, 1'b1);
      $display("test 4-wire done");
   endtask

   // reset in mid-run: 4-wire left, registers cleared, i2c works again
   task automatic t_rst_mid();
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      cmp(spi_mode, 1'b0);
      cmp(regs, 64'h0);
      run(cmd(1'b0, 1'b0, 1'b1, 8'h01, 8'h3C));
      cmp(regs[15:8], 8'h3C);
      $display("test mid reset done");
   endtask

   initial
   begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      t_reset();
      t_i2c_write();
      t_i2c_read();
      t_pointer_autoincrement();
      t_apb_err();
      t_spi();
      t_rst_mid();
      close_out();
   end
endmodule // tb
`default_nettype wire
